// File: pkg/clb_map.svh
// register offsets, field positions, reset values of the logic block
`ifndef CLB_MAP_SVH
`define CLB_MAP_SVH
`define CLB_ADDR_W 5
`define CLB_OFF_MAIN_CTRL 5'h00
`define CLB_OFF_SEQ_PAIR0 5'h01
`define CLB_OFF_SEQ_PAIR1 5'h02
`define CLB_OFF_SEQ_PAIR2 5'h03
`define CLB_OFF_IRQ_SENSE_LO 5'h05
`define CLB_OFF_IRQ_SENSE_HI 5'h06
`define CLB_OFF_IRQ_FLAGS 5'h07
`define CLB_OFF_UNIT_BASE 5'h08
`define CLB_UNIT_STRIDE 5'h04
`define CLB_SUB_CTRL_A 2'h0
`define CLB_SUB_CTRL_B 2'h1
`define CLB_SUB_CTRL_C 2'h2
`define CLB_SUB_TRUTH 2'h3
`define CLB_MAIN_ENABLE_BIT 0
`define CLB_MAIN_STANDBY_RUN_BIT 6
`define CLB_CA_ENABLE_BIT 0
`define CLB_CA_CLKSEL_LSB 1
`define CLB_CA_FILT_LSB 4
`define CLB_CA_PIN_DRIVE_BIT 6
`define CLB_CA_EDGE_BIT 7
`define CLB_CB_IN0_LSB 0
`define CLB_CB_IN1_LSB 4
`define CLB_CC_IN2_LSB 0
`define CLB_FLAGS_MASK 8'h3f
`define CLB_RESET_BYTE 8'h00
`define CLB_FILTER_DEPTH 3
`endif

// File: pkg/clb_pkg.sv
// types of the configurable logic block
`default_nettype none
package clb_pkg;
    typedef enum logic [3:0] {
        CLB_SEQ_OFF = 4'h0,
        CLB_SEQ_DFF = 4'h1,
        CLB_SEQ_JK = 4'h2,
        CLB_SEQ_DLATCH = 4'h3,
        CLB_SEQ_RS = 4'h4
    } clb_seq_mode_t;
    typedef enum logic [1:0] {
        CLB_FILT_NONE = 2'h0,
        CLB_FILT_SYNC = 2'h1,
        CLB_FILT_FILTER = 2'h2
    } clb_filt_t;
    typedef enum logic [2:0] {
        CLB_CLK_PER = 3'h0,
        CLB_CLK_IN2 = 3'h1,
        CLB_CLK_OSC_HF = 3'h4,
        CLB_CLK_OSC_SLOW = 3'h5,
        CLB_CLK_OSC_DIV32 = 3'h6
    } clb_clk_src_t;
    typedef enum logic [1:0] {
        CLB_IRQ_OFF = 2'h0,
        CLB_IRQ_RISE = 2'h1,
        CLB_IRQ_FALL = 2'h2,
        CLB_IRQ_BOTH = 2'h3
    } clb_irq_sense_t;
    typedef enum logic [3:0] {
        CLB_IN_MASK = 4'h0,
        CLB_IN_FEEDBACK = 4'h1,
        CLB_IN_LINK = 4'h2,
        CLB_IN_EVENT_A = 4'h3,
        CLB_IN_EVENT_B = 4'h4,
        CLB_IN_PIN = 4'h5,
        CLB_IN_COMPARATOR = 4'h6,
        CLB_IN_ZERO_CROSS = 4'h7,
        CLB_IN_SERIAL = 4'h8,
        CLB_IN_SPI = 4'h9,
        CLB_IN_TIMER_A0 = 4'ha,
        CLB_IN_TIMER_A1 = 4'hb,
        CLB_IN_TIMER_B = 4'hc,
        CLB_IN_TIMER_D = 4'hd
    } clb_in_src_t;
endpackage
`default_nettype wire

// File: rtl/clb_custom_logic_block.sv
// six-unit configurable lookup-table logic block with register port
`include "clb_map.svh"
`default_nettype none
// Functional notes
// - main control bit 0 enables the whole block; resets to zero
// - main control bit 6 keeps the block running during standby sleep
// - pair 0 sequencer: off, D flip-flop, JK flip-flop, D latch, RS latch
// - pair 1 and pair 2 sequencers use the same select encoding
// - two-bit sense: off, rising, falling or both edges of unit output
// - sense fields packed two bits per unit over two registers
// - unit flag in bits 5:0 set on the selected output change
// - writing one clears a flag, writing zero leaves it
// - control A bit 7 enables the unit edge detector
// - control A bit 6 drives unit output onto its own pin
// - filter select: none, synchronizer, filter; code 3 reserved
// - clock select: peripheral, input 2, fast, slow or divided oscillator
// - pair sequencer runs on the even unit's selected clock
// - control A bit 0 enables the single unit
// - input 1 source select over the shared channel-1 source list
// - input 0 source select over the shared channel-0 source list
// - unit output is truth table bit indexed by its three inputs
module clb_custom_logic_block
    import clb_pkg::*;
#(
    parameter int NUM_UNITS = 6
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [`CLB_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic standby_sleep,
    input wire logic [NUM_UNITS-1:0] unit_pin_in0,
    input wire logic [NUM_UNITS-1:0] unit_pin_in1,
    input wire logic [NUM_UNITS-1:0] unit_pin_in2,
    input wire logic [NUM_UNITS-1:0] event_channel_first,
    input wire logic [NUM_UNITS-1:0] event_channel_second,
    input wire logic [2:0] comparator_out,
    input wire logic [2:0] zero_cross_out,
    input wire logic [2:0] serial_txd,
    input wire logic spi_mosi,
    input wire logic spi_sck,
    input wire logic [2:0] timer_a_unit0_wo,
    input wire logic [2:0] timer_a_unit1_wo,
    input wire logic [2:0] timer_b_wo,
    input wire logic [2:0] timer_d_unit0_wo,
    input wire logic high_freq_oscillator,
    input wire logic slow_oscillator,
    input wire logic slow_oscillator_div32,
    output logic [NUM_UNITS-1:0] unit_out,
    output logic [NUM_UNITS-1:0] unit_pin_out,
    output logic [NUM_UNITS-1:0] unit_pin_oe,
    output logic [5:0] unit_irq_flag
);
    localparam int NUM_PAIRS = NUM_UNITS / 2;

    logic [7:0] main_ctrl_q;
    logic [3:0] seq_sel_q [NUM_PAIRS];
    logic [7:0] irq_sense_lo_q;
    logic [7:0] irq_sense_hi_q;
    logic [7:0] ctrl_a_q [NUM_UNITS];
    logic [7:0] ctrl_b_q [NUM_UNITS];
    logic [7:0] ctrl_c_q [NUM_UNITS];
    logic [7:0] truth_q [NUM_UNITS];
    logic [7:0] reg_rdata_q;
    logic [5:0] flags_q;
    logic [NUM_UNITS-1:0] unit_out_q;
    logic [NUM_UNITS-1:0] out_prev_q;
    logic [NUM_UNITS-1:0] pin_out_q;
    logic [NUM_UNITS-1:0] pin_oe_q;
    logic [NUM_UNITS-1:0] in2_prev_q;
    logic [2:0] osc_prev_q;
    logic [NUM_PAIRS-1:0] seq_q;

    logic [NUM_UNITS-1:0] tick;
    logic [NUM_UNITS-1:0] stage;
    logic [NUM_UNITS-1:0] in2_v;
    logic [NUM_UNITS-1:0] unit_d;
    logic [NUM_UNITS-1:0] edge_hit;
    logic [1:0] sense [NUM_UNITS];
    logic glob_en;
    logic clk_held;
    logic is_unit;
    logic prot_ok;
    logic [2:0] unit_idx;
    logic [1:0] unit_sub;
    logic [2:0] osc_rise;

    assign glob_en = main_ctrl_q[`CLB_MAIN_ENABLE_BIT];
    // standby without run stops every unit clock
    assign clk_held = standby_sleep &
        !main_ctrl_q[`CLB_MAIN_STANDBY_RUN_BIT];
    assign is_unit = reg_addr >= `CLB_OFF_UNIT_BASE;
    assign unit_idx = 3'(reg_addr[4:2] - 3'h2);
    assign unit_sub = reg_addr[1:0];
    assign prot_ok = !glob_en;
    assign osc_rise = {slow_oscillator_div32, slow_oscillator,
        high_freq_oscillator} & ~osc_prev_q;

    // shared source for input k of a unit
    function automatic logic pick_src(
        input logic [3:0] code,
        input int k,
        input logic fb,
        input logic link,
        input logic ev_a,
        input logic ev_b,
        input logic pin
    );
        logic r;
        r = 1'b0;
        unique case (code)
            CLB_IN_FEEDBACK: r = fb;
            CLB_IN_LINK: r = link;
            CLB_IN_EVENT_A: r = ev_a;
            CLB_IN_EVENT_B: r = ev_b;
            CLB_IN_PIN: r = pin;
            CLB_IN_COMPARATOR: r = comparator_out[k];
            CLB_IN_ZERO_CROSS: r = zero_cross_out[k];
            CLB_IN_SERIAL: r = serial_txd[k];
            CLB_IN_SPI: r = (k == 2) ? spi_sck : spi_mosi;
            CLB_IN_TIMER_A0: r = timer_a_unit0_wo[k];
            CLB_IN_TIMER_A1: r = timer_a_unit1_wo[k];
            CLB_IN_TIMER_B: r = timer_b_wo[k];
            CLB_IN_TIMER_D: r = timer_d_unit0_wo[k];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // register writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            main_ctrl_q <= `CLB_RESET_BYTE;
            irq_sense_lo_q <= `CLB_RESET_BYTE;
            irq_sense_hi_q <= `CLB_RESET_BYTE;
            for (int i = 0; i < NUM_PAIRS; i++) begin
                seq_sel_q[i] <= 4'h0;
            end
            for (int i = 0; i < NUM_UNITS; i++) begin
                ctrl_a_q[i] <= `CLB_RESET_BYTE;
                ctrl_b_q[i] <= `CLB_RESET_BYTE;
                ctrl_c_q[i] <= `CLB_RESET_BYTE;
                truth_q[i] <= `CLB_RESET_BYTE;
            end
        end else if (reg_wr) begin
            unique case (1'b1)
                reg_addr == `CLB_OFF_MAIN_CTRL: main_ctrl_q <= reg_wdata;
                reg_addr >= `CLB_OFF_SEQ_PAIR0 &&
                    reg_addr <= `CLB_OFF_SEQ_PAIR2 && prot_ok: begin
                    seq_sel_q[reg_addr[1:0] - 2'h1] <= reg_wdata[3:0];
                end
                reg_addr == `CLB_OFF_IRQ_SENSE_LO: irq_sense_lo_q <= reg_wdata;
                reg_addr == `CLB_OFF_IRQ_SENSE_HI: begin
                    irq_sense_hi_q <= {4'h0, reg_wdata[3:0]};
                end
                is_unit && prot_ok: begin
                    unique case (unit_sub)
                        `CLB_SUB_CTRL_A: ctrl_a_q[unit_idx] <= reg_wdata;
                        `CLB_SUB_CTRL_B: ctrl_b_q[unit_idx] <= reg_wdata;
                        `CLB_SUB_CTRL_C: begin
                            ctrl_c_q[unit_idx] <= {4'h0, reg_wdata[3:0]};
                        end
                        `CLB_SUB_TRUTH: truth_q[unit_idx] <= reg_wdata;
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    // read data one cycle after the read strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= `CLB_RESET_BYTE;
        end else if (reg_rd) begin
            if (is_unit) begin
                unique case (unit_sub)
                    `CLB_SUB_CTRL_A: reg_rdata_q <= ctrl_a_q[unit_idx];
                    `CLB_SUB_CTRL_B: reg_rdata_q <= ctrl_b_q[unit_idx];
                    `CLB_SUB_CTRL_C: reg_rdata_q <= ctrl_c_q[unit_idx];
                    `CLB_SUB_TRUTH: reg_rdata_q <= truth_q[unit_idx];
                endcase
            end else begin
                unique case (reg_addr)
                    `CLB_OFF_MAIN_CTRL: reg_rdata_q <= main_ctrl_q;
                    `CLB_OFF_SEQ_PAIR0: reg_rdata_q <= {4'h0, seq_sel_q[0]};
                    `CLB_OFF_SEQ_PAIR1: reg_rdata_q <= {4'h0, seq_sel_q[1]};
                    `CLB_OFF_SEQ_PAIR2: reg_rdata_q <= {4'h0, seq_sel_q[2]};
                    `CLB_OFF_IRQ_SENSE_LO: reg_rdata_q <= irq_sense_lo_q;
                    `CLB_OFF_IRQ_SENSE_HI: reg_rdata_q <= irq_sense_hi_q;
                    `CLB_OFF_IRQ_FLAGS: reg_rdata_q <= {2'h0, flags_q};
                    default: reg_rdata_q <= `CLB_RESET_BYTE;
                endcase
            end
        end else begin
            reg_rdata_q <= `CLB_RESET_BYTE;
        end
    end

    // previous levels for clock edge sensing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_prev_q <= 3'h0;
            in2_prev_q <= '0;
        end else begin
            osc_prev_q <= {slow_oscillator_div32, slow_oscillator,
                high_freq_oscillator};
            in2_prev_q <= in2_v;
        end
    end

    genvar n;
    generate
        for (n = 0; n < NUM_UNITS; n++) begin : g_unit
            localparam int LINK = (n + 1) % NUM_UNITS;
            localparam int PAIR = n / 2;
            logic in0;
            logic in1;
            logic raw;
            logic fb;
            logic filt_out;
            logic [`CLB_FILTER_DEPTH-1:0] shift_q;
            logic filt_q;
            logic edge_prev_q;

            assign fb = (n % 2 == 0 && seq_sel_q[PAIR] != CLB_SEQ_OFF) ?
                seq_q[PAIR] : unit_out_q[n];
            assign in0 = pick_src(ctrl_b_q[n][`CLB_CB_IN0_LSB +: 4], 0,
                fb, unit_out_q[LINK], event_channel_first[n],
                event_channel_second[n], unit_pin_in0[n]);
            assign in1 = pick_src(ctrl_b_q[n][`CLB_CB_IN1_LSB +: 4], 1,
                fb, unit_out_q[LINK], event_channel_first[n],
                event_channel_second[n], unit_pin_in1[n]);
            assign in2_v[n] = pick_src(ctrl_c_q[n][`CLB_CC_IN2_LSB +: 4],
                2, fb, unit_out_q[LINK], event_channel_first[n],
                event_channel_second[n], unit_pin_in2[n]);
            assign raw = truth_q[n][{in2_v[n], in1, in0}];

            // selected unit clock as a tick
            always_comb begin
                tick[n] = 1'b0;
                unique case (ctrl_a_q[n][`CLB_CA_CLKSEL_LSB +: 3])
                    CLB_CLK_PER: tick[n] = 1'b1;
                    CLB_CLK_IN2: tick[n] = in2_v[n] & !in2_prev_q[n];
                    CLB_CLK_OSC_HF: tick[n] = osc_rise[0];
                    CLB_CLK_OSC_SLOW: tick[n] = osc_rise[1];
                    CLB_CLK_OSC_DIV32: tick[n] = osc_rise[2];
                    default: tick[n] = 1'b0;
                endcase
                tick[n] = tick[n] & !clk_held;
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    shift_q <= '0;
                    filt_q <= 1'b0;
                    edge_prev_q <= 1'b0;
                end else if (tick[n]) begin
                    shift_q <= {shift_q[`CLB_FILTER_DEPTH-2:0], raw};
                    if (&shift_q || !(|shift_q)) begin
                        filt_q <= shift_q[`CLB_FILTER_DEPTH-1];
                    end
                    edge_prev_q <= filt_out;
                end
            end

            always_comb begin
                filt_out = raw;
                unique case (ctrl_a_q[n][`CLB_CA_FILT_LSB +: 2])
                    CLB_FILT_SYNC: filt_out = shift_q[1];
                    CLB_FILT_FILTER: filt_out = filt_q;
                    default: filt_out = raw;
                endcase
            end

            // edge detector gives one pulse per rising edge
            assign stage[n] = ctrl_a_q[n][`CLB_CA_EDGE_BIT] ?
                (filt_out & !edge_prev_q) : filt_out;

            always_comb begin
                unit_d[n] = stage[n];
                if (n % 2 == 0 && seq_sel_q[PAIR] != CLB_SEQ_OFF) begin
                    unit_d[n] = seq_q[PAIR];
                end
                if (clk_held && (ctrl_a_q[n][`CLB_CA_EDGE_BIT] ||
                    ctrl_a_q[n][`CLB_CA_FILT_LSB +: 2] != 2'h0 ||
                    seq_sel_q[PAIR] != CLB_SEQ_OFF)) begin
                    unit_d[n] = 1'b0;
                end
                if (!glob_en || !ctrl_a_q[n][`CLB_CA_ENABLE_BIT]) begin
                    unit_d[n] = 1'b0;
                end
            end

            always_comb begin
                edge_hit[n] = 1'b0;
                unique case (sense[n])
                    CLB_IRQ_RISE: edge_hit[n] = unit_out_q[n] & !out_prev_q[n];
                    CLB_IRQ_FALL: edge_hit[n] = !unit_out_q[n] & out_prev_q[n];
                    CLB_IRQ_BOTH: edge_hit[n] = unit_out_q[n] ^ out_prev_q[n];
                    default: edge_hit[n] = 1'b0;
                endcase
            end
        end

        for (n = 0; n < NUM_PAIRS; n++) begin : g_pair
            logic a;
            logic b;
            assign a = stage[2 * n];
            assign b = stage[2 * n + 1];
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    seq_q[n] <= 1'b0;
                end else if (tick[2 * n]) begin
                    unique case (seq_sel_q[n])
                        CLB_SEQ_DFF, CLB_SEQ_DLATCH: begin
                            if (b) begin
                                seq_q[n] <= a;
                            end
                        end
                        CLB_SEQ_JK: begin
                            if (a && b) begin
                                seq_q[n] <= !seq_q[n];
                            end else if (a || b) begin
                                seq_q[n] <= a;
                            end
                        end
                        CLB_SEQ_RS: begin
                            if (a && !b) begin
                                seq_q[n] <= 1'b1;
                            end else if (b && !a) begin
                                seq_q[n] <= 1'b0;
                            end
                        end
                        default: seq_q[n] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    assign sense[0] = irq_sense_lo_q[1:0];
    assign sense[1] = irq_sense_lo_q[3:2];
    assign sense[2] = irq_sense_lo_q[5:4];
    assign sense[3] = irq_sense_lo_q[7:6];
    assign sense[4] = irq_sense_hi_q[1:0];
    assign sense[5] = irq_sense_hi_q[3:2];

    // unit outputs and pin drive
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            unit_out_q <= '0;
            out_prev_q <= '0;
            pin_out_q <= '0;
            pin_oe_q <= '0;
        end else begin
            unit_out_q <= unit_d;
            out_prev_q <= unit_out_q;
            pin_out_q <= unit_d;
            for (int i = 0; i < NUM_UNITS; i++) begin
                pin_oe_q[i] <= glob_en &
                    ctrl_a_q[i][`CLB_CA_PIN_DRIVE_BIT];
            end
        end
    end

    // flags: a set in the clearing cycle wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= 6'h00;
        end else begin
            if (reg_wr && reg_addr == `CLB_OFF_IRQ_FLAGS) begin
                flags_q <= (flags_q & ~reg_wdata[5:0]) |
                    edge_hit[5:0];
            end else begin
                flags_q <= flags_q | edge_hit[5:0];
            end
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign unit_out = unit_out_q;
    assign unit_pin_out = pin_out_q;
    assign unit_pin_oe = pin_oe_q;
    assign unit_irq_flag = flags_q;
endmodule
`default_nettype wire

// File: testbench/clb_custom_logic_block_assertions.sv
// checker for register port, pin and flag behaviour of the logic block
`include "clb_map.svh"
`default_nettype none
module clb_custom_logic_block_chk
    import clb_pkg::*;
#(
    parameter int NUM_UNITS = 6
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [`CLB_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [NUM_UNITS-1:0] unit_out,
    input wire logic [NUM_UNITS-1:0] unit_pin_out,
    input wire logic [NUM_UNITS-1:0] unit_pin_oe,
    input wire logic [5:0] unit_irq_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside read");
    property p_gap_read;
        $past(reg_rd) && $past(reg_addr) == 5'h04 |-> reg_rdata == 8'h00;
    endproperty
    a_gap_read: assert property (p_gap_read)
        else $error("unmapped offset read not zero");
    property p_flags_read;
        $past(reg_rd) && $past(reg_addr) == 5'h07
            |-> reg_rdata == {2'b00, $past(unit_irq_flag)};
    endproperty
    a_flags_read: assert property (p_flags_read)
        else $error("flag read does not match flags");
    property p_pin_copy;
        unit_pin_out == unit_out;
    endproperty
    a_pin_copy: assert property (p_pin_copy)
        else $error("pin value differs from unit output");
    property p_oe_cause;
        $changed(unit_pin_oe)
            |-> $past(reg_wr, 2) && ($past(reg_addr, 2) & 5'h03) == 5'h00;
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("pin enable changed without control write");
    property p_clear;
        reg_wr && reg_addr == 5'h07 && unit_out == $past(unit_out)
            |=> ({2'b00, unit_irq_flag} & $past(reg_wdata)) == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("flag not cleared by write of one");
    property p_no_spurious;
        (unit_irq_flag & ~$past(unit_irq_flag)
            & ~($past(unit_out) ^ $past(unit_out, 2))) == 6'h00;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("flag set without output change");
    property p_keep;
        (~unit_irq_flag & $past(unit_irq_flag)) != 6'h00
            |-> $past(reg_wr) && $past(reg_addr) == 5'h07;
    endproperty
    a_keep: assert property (p_keep)
        else $error("flag dropped without clearing write");
    c_flag_set: cover property (unit_irq_flag == 6'h3f);
    c_oe_on: cover property (unit_pin_oe == 6'h3f);
    c_clear: cover property ($fell(unit_irq_flag[0]));
endmodule
bind clb_custom_logic_block clb_custom_logic_block_chk #(
    .NUM_UNITS(NUM_UNITS)
) u_chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .unit_out(unit_out),
    .unit_pin_out(unit_pin_out), .unit_pin_oe(unit_pin_oe),
    .unit_irq_flag(unit_irq_flag));
`default_nettype wire

// File: testbench/clb_custom_logic_block_tb.sv
// self-checking bench of the logic block register port and units
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end end
`default_nettype none
module clb_custom_logic_block_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic stby = 1'b0;
    logic [3:0] src_code = 4'h5;
    logic src_lvl = 1'b0;
    logic [5:0] pin, ev_a, ev_b, u_out, u_pin, u_oe, flags;
    logic [2:0] cmp, zcd, txd, ta0, ta1, tmb, tmd;
    logic mosi, sck;
    int bad_count = 0;
    int n_compared = 0;
    always #5 clk = ~clk;
    clb_source_model src (.clk(clk), .code(src_code), .lvl(src_lvl),
        .pin(pin), .ev_a(ev_a), .ev_b(ev_b), .cmp(cmp), .zcd(zcd),
        .txd(txd), .ta0(ta0), .ta1(ta1), .tmb(tmb), .tmd(tmd),
        .mosi(mosi), .sck(sck));
    clb_custom_logic_block dut (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_sleep(stby),
        .unit_pin_in0(pin), .unit_pin_in1(pin), .unit_pin_in2(pin),
        .event_channel_first(ev_a), .event_channel_second(ev_b),
        .comparator_out(cmp), .zero_cross_out(zcd), .serial_txd(txd),
        .spi_mosi(mosi), .spi_sck(sck), .timer_a_unit0_wo(ta0),
        .timer_a_unit1_wo(ta1), .timer_b_wo(tmb), .timer_d_unit0_wo(tmd),
        .high_freq_oscillator(1'b0), .slow_oscillator(1'b0),
        .slow_oscillator_div32(1'b0), .unit_out(u_out),
        .unit_pin_out(u_pin), .unit_pin_oe(u_oe), .unit_irq_flag(flags));
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask
    task automatic drive(input logic l, input logic [5:0] e);
        int i;
        @(posedge clk);
        src_lvl <= l;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            if (u_out === e) break;
        end
        if (i == 8) begin
            bad_count++;
            summarize();
        end
        @(posedge clk);
        #1;
        `CHK("unit_out", e, u_out)
    endtask
    initial begin
        int a, c, m, u, s;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        for (a = 0; a < 12; a++) rd(5'(a), 8'h00);
        for (a = 1; a < 4; a++) begin
            for (c = 0; c < 5; c++) begin
                wr(5'(a), {4'hf, 4'(c)});
                rd(5'(a), {4'h0, 4'(c)});
            end
            wr(5'(a), 8'h00);
        end
        for (u = 0; u < 6; u++) begin
            wr(5'(8 + 4 * u), 8'h41);
            wr(5'(9 + 4 * u), 8'h05);
            wr(5'(11 + 4 * u), 8'h02);
        end
        wr(5'h00, 8'h01);
        wr(5'h08, 8'h00);
        rd(5'h08, 8'h41);
        `CHK("unit_pin_oe", 6'h3f, u_oe)
        for (m = 0; m < 4; m++) begin
            wr(5'h05, {4{2'(m)}});
            wr(5'h06, {4'h0, {2{2'(m)}}});
            wr(5'h07, 8'hff);
            drive(1'b1, 6'h3f);
            rd(5'h07, m[0] ? 8'h3f : 8'h00);
            wr(5'h07, 8'h00);
            rd(5'h07, m[0] ? 8'h3f : 8'h00);
            wr(5'h07, 8'hff);
            drive(1'b0, 6'h00);
            rd(5'h07, m[1] ? 8'h3f : 8'h00);
        end
        wr(5'h07, 8'hff);
        rd(5'h07, 8'h00);
        wr(5'h05, 8'h00);
        wr(5'h06, 8'h00);
        for (c = 0; c < 14; c++) begin
            if (c == 1 || c == 2) continue;
            for (s = 0; s < 2; s++) begin
                wr(5'h00, 8'h00);
                src_code <= 4'(c);
                for (u = 0; u < 6; u++) begin
                    wr(5'(9 + 4 * u), s ? {4'(c), 4'h0} : {4'h0, 4'(c)});
                    wr(5'(11 + 4 * u), s ? 8'h04 : 8'h02);
                end
                wr(5'h00, 8'h01);
                drive(1'b1, c > 2 ? 6'h3f : 6'h00);
                drive(1'b0, 6'h00);
            end
        end
        wr(5'h00, 8'h00);
        wr(5'h08, 8'h40);
        wr(5'h00, 8'h01);
        drive(1'b1, 6'h3e);
        wr(5'h00, 8'h00);
        drive(1'b1, 6'h00);
        `CHK("unit_pin_oe", 6'h00, u_oe)
        for (u = 0; u < 6; u++) wr(5'(8 + 4 * u), 8'h51);
        wr(5'h00, 8'h01);
        drive(1'b1, 6'h3f);
        @(posedge clk) stby <= 1'b1;
        drive(1'b1, 6'h00);
        wr(5'h00, 8'h41);
        drive(1'b1, 6'h3f);
        summarize();
    end
endmodule
`default_nettype wire

// File: testbench/clb_source_model.sv
// far-side sources: pins, events and peripheral outputs
`default_nettype none
module clb_source_model (
    input wire logic clk,
    input wire logic [3:0] code,
    input wire logic lvl,
    output logic [5:0] pin,
    output logic [5:0] ev_a,
    output logic [5:0] ev_b,
    output logic [2:0] cmp,
    output logic [2:0] zcd,
    output logic [2:0] txd,
    output logic [2:0] ta0,
    output logic [2:0] ta1,
    output logic [2:0] tmb,
    output logic [2:0] tmd,
    output logic mosi,
    output logic sck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] hot_q = 16'h0000;
    always @(posedge clk) hot_q <= lvl ? 16'h0001 << code : 16'h0000;
    assign pin = {6{hot_q[5]}};
    assign ev_a = {6{hot_q[3]}};
    assign ev_b = {6{hot_q[4]}};
    assign cmp = {3{hot_q[6]}};
    assign zcd = {3{hot_q[7]}};
    assign txd = {3{hot_q[8]}}; // asynchronous transmitter
    assign mosi = hot_q[9]; // spi in host mode drives mosi
    assign sck = 1'b0; // no frames, host clock idle
    assign ta0 = {3{hot_q[10]}};
    assign ta1 = {3{hot_q[11]}};
    assign tmb = {3{hot_q[12]}};
    assign tmd = {3{hot_q[13]}};
endmodule
`default_nettype wire
